// file: dv/test_fcs_top.sv
// Self-checking bench for the flash command status block.
// Assumes fcs_pkg and the logic files are compiled before it.
`timescale 1ns/1ps
module test_fcs_top;
    logic                       clk;
    logic                       rst_n;
    logic [fcs_pkg::ADDR_W-1:0] busAddr;
    logic [7:0]                 busWdata;
    logic                       busWr;
    logic                       busRd;
    logic [7:0]                 busRdata;
    logic [5:0]                 ev;
    logic                       cmdLaunch;
    logic [7:0]                 cmdObject;
    logic                       eraseSuspendReq;
    logic                       irq;
    logic [7:0]                 rdVal;
    int                         failures;
    int                         numChecks;

    fcs_top i_dut (
        .clk             (clk),
        .rst_n           (rst_n),
        .busAddr         (busAddr),
        .busWdata        (busWdata),
        .busWr           (busWr),
        .busRd           (busRd),
        .busRdata        (busRdata),
        .cmdComplete     (ev[0]),
        .cmdViolation    (ev[1]),
        .seqViolation    (ev[2]),
        .protHit         (ev[3]),
        .readCollision   (ev[4]),
        .ctrlErrorEv     (ev[5]),
        .cmdLaunch       (cmdLaunch),
        .cmdObject       (cmdObject),
        .eraseSuspendReq (eraseSuspendReq),
        .irq             (irq)
    );

    always #50 clk = ~clk;

    task automatic final_report();
        $display("Checks made %0d, mismatches %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // One-cycle strobes; each task starts on a fresh edge, so no overlap
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        busWr    <= 1'b1;
        busAddr  <= a;
        busWdata <= d;
        @(posedge clk);
        busWr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        busRd   <= 1'b1;
        busAddr <= a;
        @(posedge clk);
        busRd   <= 1'b0;
        @(negedge clk);
        rdVal = busRdata;
    endtask

    task automatic st(input logic [7:0] exp);
        rd(fcs_pkg::OFF_STATUS);
        check(rdVal, exp);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev    <= '0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic launch(input logic [7:0] d, input logic exp);
        wr(fcs_pkg::OFF_STATUS, d);
        @(negedge clk);
        check(8'(cmdLaunch), 8'(exp));
    endtask

    task automatic t_init();
        int n = 0;
        st(8'h00);
        while (rdVal[7] !== 1'b1 && n < 40) begin
            rd(fcs_pkg::OFF_STATUS);
            n++;
        end
        if (n >= 40) begin
            failures++;
            final_report();
        end else begin
            check(rdVal, 8'h80);
        end
    endtask

    // Mid-run reset: the command object reopens to writes until init ends
    task automatic t_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        idle(2);
        check(cmdObject, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        wr(fcs_pkg::OFF_CMD_OBJ, 8'h66);
        idle(0);
        check(cmdObject, 8'h66);
        t_init();
    endtask

    task automatic t_launch();
        launch(8'h80, 1'b1);
        st(8'h00);
        launch(8'h80, 1'b0);
        pulse(0);
        st(8'h80);
        launch(8'h00, 1'b0);
        st(8'h80);
        launch(8'h80, 1'b1);
        pulse(1);
        st(8'h80);
    endtask

    task automatic t_flags();
        logic [7:0] m;
        pulse(4);
        st(8'hC0);
        wr(fcs_pkg::OFF_STATUS, 8'h0E);
        st(8'hC0);
        wr(fcs_pkg::OFF_STATUS, 8'h40);
        st(8'h80);
        // Both launch-blocking errors share the same sequence
        for (int k = 0; k < 2; k++) begin
            m = (k == 0) ? 8'h20 : 8'h10;
            pulse(2 + k);
            st(8'h80 | m);
            launch(8'h80, 1'b0);
            st(8'h80 | m);
            wr(fcs_pkg::OFF_STATUS, 8'h00);
            st(8'h80 | m);
            wr(fcs_pkg::OFF_STATUS, m);
            st(8'h80);
        end
        pulse(5);
        st(8'h81);
        wr(fcs_pkg::OFF_STATUS, 8'h01);
        st(8'h81);
        launch(8'h80, 1'b1);
        st(8'h00);
        pulse(0);
        st(8'h80);
    endtask

    task automatic t_obj();
        wr(fcs_pkg::OFF_CMD_OBJ, 8'h3C);
        idle(0);
        check(cmdObject, 8'h3C);
        launch(8'h80, 1'b1);
        wr(fcs_pkg::OFF_CMD_OBJ, 8'h5A);
        idle(0);
        check(cmdObject, 8'h3C);
        wr(fcs_pkg::OFF_CONFIG, 8'h10);
        idle(1);
        check(8'(eraseSuspendReq), 8'h01);
        pulse(0);
        wr(fcs_pkg::OFF_CMD_OBJ, 8'hA5);
        idle(0);
        check(cmdObject, 8'h3C);
        wr(fcs_pkg::OFF_CONFIG, 8'h00);
        wr(fcs_pkg::OFF_CMD_OBJ, 8'hA5);
        idle(0);
        check(cmdObject, 8'hA5);
        rd(4'hF);
        check(rdVal, 8'h00);
    endtask

    task automatic t_irq();
        wr(fcs_pkg::OFF_CONFIG, 8'hC0);
        wr(fcs_pkg::OFF_IRQ_MASK, 8'h01);
        wr(fcs_pkg::OFF_IRQ_STAT, 8'h03);
        pulse(4);
        idle(3);
        check(8'(irq), 8'h00);
        rd(fcs_pkg::OFF_IRQ_STAT);
        check(rdVal, 8'h02);
        wr(fcs_pkg::OFF_STATUS, 8'h40);
        wr(fcs_pkg::OFF_IRQ_STAT, 8'h03);
        wr(fcs_pkg::OFF_IRQ_MASK, 8'h02);
        pulse(4);
        idle(3);
        check(8'(irq), 8'h01);
        wr(fcs_pkg::OFF_STATUS, 8'h40);
        wr(fcs_pkg::OFF_IRQ_STAT, 8'h02);
        idle(2);
        check(8'(irq), 8'h00);
        wr(fcs_pkg::OFF_IRQ_MASK, 8'h01);
        launch(8'h80, 1'b1);
        idle(3);
        check(8'(irq), 8'h00);
        pulse(0);
        idle(3);
        check(8'(irq), 8'h01);
        wr(fcs_pkg::OFF_IRQ_STAT, 8'h01);
        idle(2);
        check(8'(irq), 8'h00);
    endtask

    initial begin
        clk       = 1'b0;
        rst_n     = 1'b0;
        busAddr   = '0;
        busWdata  = 8'h00;
        busWr     = 1'b0;
        busRd     = 1'b0;
        ev        = '0;
        failures  = 0;
        numChecks = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_init();
        t_launch();
        t_flags();
        t_obj();
        t_irq();
        t_reset();
        final_report();
    end
endmodule // test_fcs_top

// file: logic/fcs_init_seq.sv
// Reset initialisation timer: counts after reset, then signals done.
// Assumes rst_n is already synchronous to clk on release.
`timescale 1ns/1ps
module fcs_init_seq #(
    parameter int CYCLES = fcs_pkg::INIT_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      initDone
);
    logic [15:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= 16'h0000;
            initDone <= 1'b0;
        end else if (!initDone) begin
            cnt_q    <= cnt_q + 16'h0001;
            initDone <= (cnt_q == 16'(CYCLES - 1));
        end
    end
endmodule // fcs_init_seq

// file: logic/fcs_top.sv
// Flash command status register logic with launch gating and interrupt.
// Assumes the command engine and read arbiter run on the same clock.
// Notes on behaviour
// - Writing one to bit 7 launches a command and clears the done flag until completion or violation sets it.
// - The done flag resets to zero and sets when reset initialisation ends.
// - A read hitting a resource under command sets the collision flag, bit 6.
// - Writing one clears the collision flag, zero leaves it.
// - A sequence violation sets the access error flag, bit 5; a command violation only ends the command.
// - While access error is set a done-flag write neither clears it nor launches.
// - Access error clears only by writing one to it.
// - Program or erase of a protected address sets protection violation, bit 4.
// - While protection violation is set a done-flag write neither clears it nor launches.
// - Protection violation clears only by writing one to it.
// - Bits 3 to 1 read zero and ignore writes.
// - Controller error status, bit 0, is set by hardware and read-only.
// - Controller error status is discarded during the next command.
// - While running or suspending, writes to the command object register are refused, except during initialisation.
// - With the done interrupt enable set, a set done flag raises an interrupt; the irq output also needs irqMask_q bit 0 set.
// - With the collision interrupt enable set, a collision raises an interrupt; the irq output also needs irqMask_q bit 1 set.
`timescale 1ns/1ps
module fcs_top (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic [fcs_pkg::ADDR_W-1:0] busAddr,
    input  wire logic [7:0]              busWdata,
    input  wire logic                    busWr,
    input  wire logic                    busRd,
    output logic      [7:0]              busRdata,
    input  wire logic                    cmdComplete,
    input  wire logic                    cmdViolation,
    input  wire logic                    seqViolation,
    input  wire logic                    protHit,
    input  wire logic                    readCollision,
    input  wire logic                    ctrlErrorEv,
    output logic                         cmdLaunch,
    output logic      [7:0]              cmdObject,
    output logic                         eraseSuspendReq,
    output logic                         irq
);
    fcs_pkg::fcs_bus_t    bus;
    fcs_pkg::fcs_events_t flags;
    logic       doneFlag_q;
    logic       ctrlErr_q;
    logic       collFlag;
    logic       accFlag;
    logic       protFlag;
    logic       initDone;
    logic       initSeen_q;
    logic [7:0] config_q;
    logic [1:0] irqStat_q;
    logic [1:0] irqMask_q;
    logic       running_q;
    logic       stWr;
    logic       launchOk;
    logic       doneSet;
    logic       irqDoneEv;
    logic       irqCollEv;
    logic [1:0] irqEv;
    logic [7:0] statusByte;
    logic [7:0] rdData_d;

    assign bus = '{wr: busWr, rd: busRd, addr: busAddr, wdata: busWdata};
    assign stWr = bus.wr && (bus.addr == fcs_pkg::OFF_STATUS);

    // Flags live in separate registers so that each has a single writer
    assign flags = '{done:      doneFlag_q,
                     readColl:  collFlag,
                     accessErr: accFlag,
                     protViol:  protFlag,
                     ctrlErr:   ctrlErr_q};

    // Launch only when idle and no access or protection error pends
    assign launchOk = stWr && bus.wdata[fcs_pkg::BIT_DONE]
                      && flags.done && !running_q
                      && !flags.accessErr
                      && !flags.protViol;

    assign doneSet = (initDone && !initSeen_q)
                     || (running_q && (cmdComplete || cmdViolation));

    fcs_init_seq #(.CYCLES(fcs_pkg::INIT_CYCLES)) uInit (
        .clk      (clk),
        .rst_n    (rst_n),
        .initDone (initDone)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            initSeen_q <= 1'b0;
        end else begin
            initSeen_q <= initDone;
        end
    end

    // Done flag and running state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            doneFlag_q <= 1'b0;
            running_q  <= 1'b0;
            cmdLaunch  <= 1'b0;
        end else begin
            cmdLaunch <= launchOk;
            if (doneSet) begin
                doneFlag_q <= 1'b1;
                running_q  <= 1'b0;
            end else if (launchOk) begin
                doneFlag_q <= 1'b0;
                running_q  <= 1'b1;
            end
        end
    end

    fcs_w1c_flag uColl (
        .clk   (clk),
        .rst_n (rst_n),
        .setEv (readCollision),
        .clrEv (stWr && bus.wdata[fcs_pkg::BIT_COLL]),
        .flag  (collFlag)
    );

    fcs_w1c_flag uAcc (
        .clk   (clk),
        .rst_n (rst_n),
        .setEv (seqViolation),
        .clrEv (stWr && bus.wdata[fcs_pkg::BIT_ACCESS_ERROR_FLAG]),
        .flag  (accFlag)
    );

    fcs_w1c_flag uProt (
        .clk   (clk),
        .rst_n (rst_n),
        .setEv (protHit),
        .clrEv (stWr && bus.wdata[fcs_pkg::BIT_PROT]),
        .flag  (protFlag)
    );

    // Controller error: no software clear; the next launch discards it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlErr_q <= 1'b0;
        end else if (ctrlErrorEv) begin
            ctrlErr_q <= 1'b1;
        end else if (cmdLaunch) begin
            ctrlErr_q <= 1'b0;
        end
    end

    // Config: enables and suspend are always writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_q <= fcs_pkg::RST_BYTE;
        end else if (bus.wr && bus.addr == fcs_pkg::OFF_CONFIG) begin
            config_q <= {bus.wdata[7:6], 1'b0, bus.wdata[4], 4'h0};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eraseSuspendReq <= 1'b0;
        end else begin
            eraseSuspendReq <= config_q[fcs_pkg::BIT_SUSP];
        end
    end

    // Command object is locked while busy or suspending after init
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdObject <= fcs_pkg::RST_BYTE;
        end else if (bus.wr && bus.addr == fcs_pkg::OFF_CMD_OBJ
                     && (!initSeen_q || (flags.done
                     && !config_q[fcs_pkg::BIT_SUSP]))) begin
            cmdObject <= bus.wdata;
        end
    end

    assign irqDoneEv = config_q[fcs_pkg::BIT_DONE] && doneSet;
    assign irqCollEv = config_q[fcs_pkg::BIT_COLL] && readCollision;
    assign irqEv     = {irqCollEv, irqDoneEv};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqMask_q <= fcs_pkg::RST_IRQ;
        end else if (bus.wr && bus.addr == fcs_pkg::OFF_IRQ_MASK) begin
            irqMask_q <= bus.wdata[1:0];
        end
    end

    // Sticky interrupt status, set beats a write-one clear
    for (genvar i = 0; i < 2; i++) begin : g_irq
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                irqStat_q[i] <= fcs_pkg::RST_IRQ[i];
            end else if (irqEv[i]) begin
                irqStat_q[i] <= 1'b1;
            end else if (bus.wr && bus.addr == fcs_pkg::OFF_IRQ_STAT
                         && bus.wdata[i]) begin
                irqStat_q[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    assign statusByte = {flags.done, flags.readColl, flags.accessErr,
                         flags.protViol, 3'h0, flags.ctrlErr};

    always_comb begin
        rdData_d = 8'h00;
        case (bus.addr)
            fcs_pkg::OFF_STATUS:   rdData_d = statusByte;
            fcs_pkg::OFF_CONFIG:   rdData_d = config_q;
            fcs_pkg::OFF_IRQ_STAT: rdData_d = {6'h00, irqStat_q};
            fcs_pkg::OFF_IRQ_MASK: rdData_d = {6'h00, irqMask_q};
            fcs_pkg::OFF_CMD_OBJ:  rdData_d = cmdObject;
            default:               rdData_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busRdata <= 8'h00;
        end else begin
            busRdata <= bus.rd ? rdData_d : 8'h00;
        end
    end

    a_launch_blocked: assert property (
        @(posedge clk) disable iff (!rst_n)
        (stWr && (flags.accessErr || flags.protViol))
        |=> !cmdLaunch)
        else $error("launch despite pending error");

    a_launch_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        (stWr && (!bus.wdata[fcs_pkg::BIT_DONE] || !flags.done))
        |=> !cmdLaunch)
        else $error("launch accepted while busy or on zero");

    a_done_zero_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flags.done && stWr && !bus.wdata[fcs_pkg::BIT_DONE])
        |=> flags.done)
        else $error("done flag cleared by a zero write");

    a_done_after_launch: assert property (
        @(posedge clk) disable iff (!rst_n)
        launchOk
        |=> !flags.done && cmdLaunch)
        else $error("done flag not cleared on launch");

    a_done_on_end: assert property (
        @(posedge clk) disable iff (!rst_n)
        (running_q && (cmdComplete || cmdViolation))
        |=> flags.done)
        else $error("done flag not set at command end");

    a_done_held_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        (running_q && !cmdComplete && !cmdViolation)
        |=> !flags.done)
        else $error("done flag set while command runs");

    a_acc_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        seqViolation
        |=> flags.accessErr)
        else $error("access error not flagged");

    a_acc_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flags.accessErr && !(stWr && bus.wdata[fcs_pkg::BIT_ACCESS_ERROR_FLAG]))
        |=> flags.accessErr)
        else $error("access error dropped without clear");

    a_prot_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        protHit
        |=> flags.protViol)
        else $error("protection violation not flagged");

    a_prot_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flags.protViol && !(stWr && bus.wdata[fcs_pkg::BIT_PROT]))
        |=> flags.protViol)
        else $error("protection flag dropped without clear");

    a_coll_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        readCollision
        |=> flags.readColl)
        else $error("collision not flagged");

    a_coll_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flags.readColl && !(stWr && bus.wdata[fcs_pkg::BIT_COLL]))
        |=> flags.readColl)
        else $error("collision dropped without clear");

    a_resv_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (bus.rd && bus.addr == fcs_pkg::OFF_STATUS)
        |=> busRdata[3:1] == 3'h0)
        else $error("reserved status bits nonzero");

    a_init_done: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(initSeen_q)
        |-> flags.done)
        else $error("done flag not set after init");

    a_ctrl_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        ctrlErrorEv
        |=> flags.ctrlErr)
        else $error("controller error not flagged");

    a_ctrl_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (flags.ctrlErr && !cmdLaunch)
        |=> flags.ctrlErr)
        else $error("controller error lost");

    a_ctrl_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (cmdLaunch && !ctrlErrorEv)
        |=> !flags.ctrlErr)
        else $error("controller error kept past launch");

    a_obj_locked: assert property (
        @(posedge clk) disable iff (!rst_n)
        (bus.wr && initSeen_q
         && (!flags.done || config_q[fcs_pkg::BIT_SUSP]))
        |=> $stable(cmdObject))
        else $error("command object written while locked");

    a_done_irq_stat: assert property (
        @(posedge clk) disable iff (!rst_n)
        irqDoneEv
        |=> irqStat_q[fcs_pkg::IRQ_DONE])
        else $error("done interrupt status not set");

    a_done_irq_out: assert property (
        @(posedge clk) disable iff (!rst_n)
        (irqDoneEv ##1 irqMask_q[fcs_pkg::IRQ_DONE])
        |=> irq)
        else $error("done interrupt missing");

    a_coll_irq_stat: assert property (
        @(posedge clk) disable iff (!rst_n)
        irqCollEv
        |=> irqStat_q[fcs_pkg::IRQ_COLL])
        else $error("collision interrupt status not set");
endmodule // fcs_top

// file: logic/fcs_w1c_flag.sv
// One sticky flag: hardware set, software write-one clear.
// Set wins over a clear in the same cycle.
`timescale 1ns/1ps
module fcs_w1c_flag (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic setEv,
    input  wire logic clrEv,
    output logic      flag
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (setEv) begin
            flag <= 1'b1;
        end else if (clrEv) begin
            flag <= 1'b0;
        end
    end
endmodule // fcs_w1c_flag

// file: pkg/fcs_pkg.sv
// Package for the flash command status block.
// Assumes one system clock; the register port is byte wide.
package fcs_pkg;
    localparam int          ADDR_W       = 4;
    localparam logic [3:0]  OFF_STATUS   = 4'h0;
    localparam logic [3:0]  OFF_CONFIG   = 4'h1;
    localparam logic [3:0]  OFF_IRQ_STAT = 4'h2;
    localparam logic [3:0]  OFF_IRQ_MASK = 4'h3;
    localparam logic [3:0]  OFF_CMD_OBJ  = 4'h4;
    localparam int          BIT_DONE     = 7;
    localparam int          BIT_COLL     = 6;
    localparam int          BIT_ACCESS_ERROR_FLAG   = 5;
    localparam int          BIT_PROT     = 4;
    localparam int          BIT_CTRLERR  = 0;
    localparam int          BIT_SUSP     = 4;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [1:0]  RST_IRQ      = 2'h0;
    localparam int          INIT_CYCLES  = 16;
    localparam int          IRQ_DONE     = 0;
    localparam int          IRQ_COLL     = 1;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [7:0]          wdata;
    } fcs_bus_t;

    typedef struct packed {
        logic done;
        logic readColl;
        logic accessErr;
        logic protViol;
        logic ctrlErr;
    } fcs_events_t;
endpackage
